// ===== hdl/gpio_port_change_notify.sv
`timescale 1ns/1ps
`include "gpio_port_regs.svh"

module gpio_port_change_notify
    import gpio_port_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins
    input  wire logic [15:0] pin_in,
    output logic      [15:0] pin_out,
    output logic      [15:0] pin_oe,
    output logic      [15:0] pull_up_en,
    output logic      [15:0] pull_down_en,
    output logic      [15:0] analog_mode,
    // Interrupt request to the processor
    output logic             change_irq
);

    port_word_t analog_select;
    port_word_t direction_reg;
    port_word_t output_latch;
    port_word_t open_drain_ctl;
    port_word_t pull_up_enable;
    port_word_t pull_down_enable;
    port_word_t change_notify_ctl;
    port_word_t change_irq_enable;
    port_word_t change_status;
    port_word_t pin_sample;
    port_word_t pin_prev;

    logic       wr_acc;
    logic       rd_acc;
    logic [7:0] reg_sel;
    write_op_t  op;
    port_word_t wdata;
    port_word_t pin_level_view;
    port_word_t next_latch;
    port_word_t change_seen;
    port_word_t read_clear;

    function automatic port_word_t apply_op(input port_word_t cur, input port_word_t val,
                                            input write_op_t o);
        case (o)
            OP_WRITE: apply_op = val;
            OP_CLR:   apply_op = cur & ~val;
            OP_SET:   apply_op = cur | val;
            OP_INV:   apply_op = cur ^ val;
            default:  apply_op = cur;
        endcase
    endfunction

    function automatic logic hit(input logic [11:0] ofs);
        hit = wr_acc && (paddr[11:4] == ofs[11:4]);
    endfunction

    // Unmapped offsets and byte addresses flag an error; unmapped writes hit nothing, byte-address writes still land
    function automatic logic bad_addr(input logic [11:0] a);
        bad_addr = (a[11:4] > (`OFS_CHANGE_STATUS >> 4)) || (a[1:0] != 2'h0);
    endfunction

    function automatic logic [31:0] read_word(input logic [11:0] a);
        read_word = 32'h00000000;
        if (write_op_t'(a[3:2]) != OP_WRITE) begin
            read_word = `COMPANION_READ;
        end else begin
            case (a[11:4])
                8'h00:   read_word = {16'h0000, analog_select};
                8'h01:   read_word = {16'h0000, direction_reg};
                8'h02:   read_word = {16'h0000, pin_level_view};
                8'h03:   read_word = {16'h0000, output_latch};
                8'h04:   read_word = {16'h0000, open_drain_ctl};
                8'h05:   read_word = {16'h0000, pull_up_enable};
                8'h06:   read_word = {16'h0000, pull_down_enable};
                8'h07:   read_word = {16'h0000, change_notify_ctl};
                8'h08:   read_word = {16'h0000, change_irq_enable};
                8'h09:   read_word = {16'h0000, change_status};
                default: read_word = 32'h00000000;
            endcase
        end
    endfunction

    // Zero-wait APB: every access completes in its first access cycle
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign reg_sel = paddr[11:4];
    assign op = write_op_t'(paddr[3:2]);
    assign wdata = pwdata[15:0];

    // Analog inputs read low
    assign pin_level_view = pin_sample & ~(analog_select & direction_reg);

    // Level writes and latch writes both land in the latch
    always_comb begin
        next_latch = output_latch;
        if (hit(`OFS_OUTPUT_LATCH) || hit(`OFS_PIN_LEVEL_REG)) begin
            next_latch = apply_op(output_latch, wdata, op);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            output_latch <= `RST_ZERO;
        end else begin
            output_latch <= next_latch;
        end
    end

    // Pins come out of reset analog so no digital buffer sees a mid-rail level
    always_ff @(posedge clock) begin
        if (srst) begin
            analog_select <= `RST_ANALOG_SELECT;
        end else if (hit(`OFS_ANALOG_SELECT)) begin
            analog_select <= apply_op(analog_select, wdata, op);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            direction_reg <= `RST_DIRECTION_REG;
        end else if (hit(`OFS_DIRECTION_REG)) begin
            direction_reg <= apply_op(direction_reg, wdata, op);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            open_drain_ctl <= `RST_ZERO;
        end else if (hit(`OFS_OPEN_DRAIN_CTL)) begin
            open_drain_ctl <= apply_op(open_drain_ctl, wdata, op);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pull_up_enable <= `RST_ZERO;
        end else if (hit(`OFS_PULL_UP_ENABLE)) begin
            pull_up_enable <= apply_op(pull_up_enable, wdata, op);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pull_down_enable <= `RST_ZERO;
        end else if (hit(`OFS_PULL_DOWN_ENABLE)) begin
            pull_down_enable <= apply_op(pull_down_enable, wdata, op);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            change_notify_ctl <= `RST_ZERO;
        end else if (hit(`OFS_CHANGE_NOTIFY_CTL)) begin
            change_notify_ctl <= apply_op(change_notify_ctl, wdata, op);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            change_irq_enable <= `RST_ZERO;
        end else if (hit(`OFS_CHANGE_IRQ_ENABLE)) begin
            change_irq_enable <= apply_op(change_irq_enable, wdata, op);
        end
    end

    // Pins are synchronous inputs; one sample stage feeds reads and detection
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_sample <= `RST_ZERO;
            pin_prev   <= `RST_ZERO;
        end else begin
            pin_sample <= pin_in;
            pin_prev   <= pin_sample;
        end
    end

    // Only digital inputs with their enable set can flag a change
    assign change_seen = (pin_sample ^ pin_prev) & direction_reg & ~analog_select
                         & change_irq_enable & {16{change_notify_ctl[`CNCTL_ON_BIT]}};

    // A base read of the pin level clears the status of every bit read
    assign read_clear = (rd_acc && reg_sel == `OFS_PIN_LEVEL_REG >> 4 && op == OP_WRITE)
                        ? 16'hffff : 16'h0000;

    // Set wins over the read clear so a change in that cycle survives
    always_ff @(posedge clock) begin
        if (srst) begin
            change_status <= `RST_ZERO;
        end else begin
            change_status <= (change_status & ~read_clear) | change_seen;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            change_irq <= 1'b0;
        end else begin
            change_irq <= |(next_status_irq(change_status, change_irq_enable));
        end
    end

    function automatic port_word_t next_status_irq(input port_word_t st, input port_word_t en);
        next_status_irq = st & en;
    endfunction

    // Pin drivers, registered so outputs come straight from flops
    // Open-drain: drive zero only, release on one; push-pull otherwise
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_out <= `RST_ZERO;
        end else begin
            pin_out <= next_latch & ~(open_drain_ctl & ~direction_reg);
        end
    end

    // Analog-selected outputs still drive, so a converter can read the level back
    always_ff @(posedge clock) begin
        if (srst) begin
            pin_oe <= `RST_ZERO;
        end else begin
            pin_oe <= ~direction_reg & ~(open_drain_ctl & next_latch);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pull_up_en <= `RST_ZERO;
        end else begin
            pull_up_en <= pull_up_enable;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pull_down_en <= `RST_ZERO;
        end else begin
            pull_down_en <= pull_down_enable;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            analog_mode <= `RST_ANALOG_SELECT;
        end else begin
            analog_mode <= analog_select;
        end
    end

    // Zero-wait answer: pready rises in the first access cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && !penable && bad_addr(paddr);
        end
    end

    // Read data is taken at setup; it stands only while pready is high
    always_ff @(posedge clock) begin
        if (srst) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata <= read_word(paddr);
        end else begin
            prdata <= 32'h00000000;
        end
    end

endmodule

// ===== hdl/gpio_port_pkg.sv
package gpio_port_pkg;
    typedef enum logic [1:0] {
        OP_WRITE = 2'h0,
        OP_CLR   = 2'h1,
        OP_SET   = 2'h2,
        OP_INV   = 2'h3
    } write_op_t;
    typedef logic [15:0] port_word_t;
endpackage

// ===== hdl/gpio_port_regs.svh
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

`define PORT_WIDTH          16
`define ADDR_WIDTH          12
// Register bases (byte addresses); each but OFS_CHANGE_STATUS has clr/set/inv companions at +4/+8/+c
`define OFS_ANALOG_SELECT   12'h000
`define OFS_DIRECTION_REG   12'h010
`define OFS_PIN_LEVEL_REG   12'h020
`define OFS_OUTPUT_LATCH    12'h030
`define OFS_OPEN_DRAIN_CTL  12'h040
`define OFS_PULL_UP_ENABLE  12'h050
`define OFS_PULL_DOWN_ENABLE 12'h060
`define OFS_CHANGE_NOTIFY_CTL 12'h070
`define OFS_CHANGE_IRQ_ENABLE 12'h080
`define OFS_CHANGE_STATUS   12'h090
`define SUB_BASE            2'h0
`define SUB_CLR             2'h1
`define SUB_SET             2'h2
`define SUB_INV             2'h3
// Field positions in change_notify_ctl
`define CNCTL_ON_BIT        15
// Reset values
`define RST_ANALOG_SELECT   16'hffff
`define RST_DIRECTION_REG   16'hffff
`define RST_ZERO            16'h0000
// Value returned on companion reads
`define COMPANION_READ      32'h00000000

`endif

// ===== tb/gpio_pin_model.sv
`timescale 1ns/1ps
module gpio_pin_model (
    // Design side
    input  wire logic        clock,
    input  wire logic [15:0] pin_out, pin_oe, pull_up_en, pull_down_en,
    // Bench side
    input  wire logic [15:0] ext_en, ext_val,
    output logic      [15:0] pin_level
);
    // Floating pins toggle so no value settles by luck
    logic [15:0] float_bits = 16'h5a5a;
    always_ff @(posedge clock) begin
        float_bits <= ~float_bits;
    end
    assign pin_level = pin_oe & pin_out | ~pin_oe & (ext_en & ext_val
        | ~ext_en & (pull_up_en | ~pull_down_en & float_bits));
endmodule

// ===== tb/gpio_port_change_notify_tb_top.sv
`timescale 1ns/1ps
module gpio_port_change_notify_tb_top;
    logic        clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, change_irq;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, d;
    logic [15:0] pin_in, pin_out, pin_oe, pull_up_en, pull_down_en, analog_mode, r, m;
    logic [15:0] ext_en = 16'h0000, ext_val = 16'h0000;
    logic [32:0] expect_q[$];
    int          bad_count = 0, samples_checked = 0;

    gpio_port_change_notify gpio_port_change_notify_i (.clock, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pull_up_en, .pull_down_en,
        .analog_mode, .change_irq);
    gpio_pin_model gpio_pin_model_i (.clock, .pin_out, .pin_oe, .pull_up_en, .pull_down_en, .ext_en,
        .ext_val, .pin_level(pin_in));

    initial forever #4 clock = ~clock;

    task automatic test_done();
        $display("checks %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] dat);
        int n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge clock);
        penable <= 1'b1;
        // Request stands until the edge that samples pready high
        do @(posedge clock); while (!pready && n++ < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) bad_count++;
    endtask

    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        if (a == 12'h020) repeat (3) @(posedge clock);
        expect_q.push_back(e);
        apb(a, 1'b0, 32'h0);
    endtask

    always @(posedge clock) begin
        if (psel && penable && pready && !pwrite && expect_q.size() > 0)
            check({pslverr, prdata}, expect_q.pop_front());
    end

    initial begin
        #100000;
        bad_count++;
        test_done();
    end

    initial begin
        void'($urandom(51053));
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        rd(12'h000, 33'hffff);
        rd(12'h010, 33'hffff);
        rd(12'h0a0, 33'h100000000);
        d = $urandom;
        apb(12'h030, 1'b1, d);
        r = d[15:0];
        rd(12'h030, {17'h0, r});
        for (int k = 1; k < 4; k++) begin
            d = $urandom;
            apb(12'h030 + 12'(4 * k), 1'b1, d);
            r = k == 1 ? r & ~d[15:0] : k == 2 ? r | d[15:0] : r ^ d[15:0];
            rd(12'h030, {17'h0, r});
            rd(12'h030 + 12'(4 * k), 33'h0);
        end
        d = $urandom;
        apb(12'h020, 1'b1, d);
        rd(12'h030, {17'h0, d[15:0]});
        apb(12'h010, 1'b1, 32'h0);
        rd(12'h020, {17'h0, d[15:0]});
        apb(12'h000, 1'b1, 32'h0);
        apb(12'h040, 1'b1, 32'hffff);
        ext_en <= 16'hffff;
        ext_val <= 16'hffff;
        rd(12'h020, {17'h0, d[15:0]});
        ext_val <= 16'h0000;
        rd(12'h020, 33'h0);
        apb(12'h040, 1'b1, 32'h0);
        apb(12'h010, 1'b1, 32'hffff);
        ext_en <= 16'h0000;
        apb(12'h050, 1'b1, 32'hffff);
        rd(12'h020, 33'hffff);
        apb(12'h050, 1'b1, 32'h0);
        apb(12'h060, 1'b1, 32'hffff);
        rd(12'h020, 33'h0);
        apb(12'h060, 1'b1, 32'h0);
        ext_en <= 16'hffff;
        ext_val <= d[31:16];
        apb(12'h000, 1'b1, 32'hffff);
        rd(12'h020, 33'h0);
        apb(12'h000, 1'b1, 32'h0);
        rd(12'h020, {17'h0, d[31:16]});
        m = 16'($urandom) | 16'h0001;
        r = m & -m;
        apb(12'h070, 1'b1, 32'h8000);
        apb(12'h080, 1'b1, {16'h0, m});
        rd(12'h020, {17'h0, d[31:16]});
        ext_val <= d[31:16] ^ ~m;
        repeat (6) @(posedge clock);
        check({32'h0, change_irq}, 33'h0);
        ext_val <= d[31:16] ^ ~m ^ r;
        repeat (6) @(posedge clock);
        check({32'h0, change_irq}, 33'h1);
        rd(12'h090, {17'h0, r});
        rd(12'h020, {17'h0, d[31:16] ^ ~m ^ r});
        repeat (6) @(posedge clock);
        check({32'h0, change_irq}, 33'h0);
        repeat (4) @(posedge clock);
        if (expect_q.size() != 0) bad_count++;
        test_done();
    end
endmodule

// ===== tb/gpio_port_checker_assertions.sv
`timescale 1ns/1ps
module gpio_port_checker (
    // Bus and control
    input wire logic        clock, srst, psel, penable, pwrite, pready, pslverr, change_irq,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    // Pin side
    input wire logic [15:0] pin_oe, analog_mode
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_read;
        s_setup ##1 pready && !pwrite;
    endsequence
    AST_PREADY_NEXT: assert property (s_setup |=> pready)
        else $error("no answer after setup");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready held");
    AST_RST_DIR: assert property ($fell(srst) |-> pin_oe == 16'h0000)
        else $error("pin driven after reset");
    AST_RST_ANALOG: assert property ($fell(srst) |-> analog_mode == 16'hffff && !change_irq)
        else $error("analog mode not all set after reset");
    AST_DIR_INPUT: assert property (psel && penable && pready && pwrite && paddr == 12'h010
        |-> ##2 (pin_oe & 16'($past(pwdata, 2))) == 16'h0000) else $error("input pin still driven");
    AST_COMPANION: assert property (s_read ##0 paddr[3:2] != 2'h0 && !pslverr |-> prdata == 32'h0)
        else $error("companion read not zero");
    AST_UPPER: assert property (s_read |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    AST_ANALOG_READ: assert property (s_read ##0 paddr == 12'h020
        |-> (prdata[15:0] & analog_mode & ~pin_oe) == 16'h0000) else $error("analog pin read high");
    AST_UNMAPPED: assert property (s_read ##0 paddr > 12'h09c |-> pslverr)
        else $error("unmapped read accepted");
endmodule

bind gpio_port_change_notify gpio_port_checker gpio_port_checker_i (.clock, .srst, .psel, .penable, .pwrite,
    .pready, .pslverr, .change_irq, .paddr, .pwdata, .prdata, .pin_oe, .analog_mode);
